// ===== logic/dbg_link_pkg.sv
// constants, codes and types shared by both ends of the debug link
package dbg_link_pkg;
  // target data register selections, SFR page and register reset value
  localparam logic [7:0] SEL_PART_ALT     = 8'h00;
  localparam logic [7:0] SEL_REV_ALT      = 8'h01;
  localparam logic [7:0] SEL_PROG_CONTROL = 8'h02;
  localparam logic [7:0] SEL_PROG_DATA    = 8'hB4;
  localparam logic [7:0] SEL_PART         = 8'hFD;
  localparam logic [7:0] SEL_REV          = 8'hFE;
  localparam logic [7:0] SFR_PAGE_ID      = 8'h0F;
  localparam logic [7:0] REG_RESET        = 8'h00;
  // unlock codes, in the order the control register must see them
  localparam logic [7:0] UNLOCK_FIRST     = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND    = 8'h01;
  // part code: arbitrary value
  localparam logic [7:0] PART_ID_VALUE    = 8'h5A;
  // revision code default: arbitrary value
  localparam logic [7:0] REV_ID_DEFAULT   = 8'h00;

  typedef enum logic [7:0] {
    CMD_DEVICE_ERASE = 8'h03,
    CMD_BLOCK_READ   = 8'h06,
    CMD_BLOCK_WRITE  = 8'h07,
    CMD_PAGE_ERASE   = 8'h08
  } flash_cmd_type;

  // frame instruction, sent low bit first after the start bit
  typedef enum logic [1:0] {
    INS_DATA_READ  = 2'b00,
    INS_DATA_WRITE = 2'b01,
    INS_ADDR_READ  = 2'b10,
    INS_ADDR_WRITE = 2'b11
  } link_ins_type;

  // frame layout in link clock periods
  localparam logic [3:0] FRAME_BITS    = 4'd12;
  localparam logic [3:0] DATA_FIRST    = 4'd3;
  localparam logic [3:0] SAMPLE_FIRST  = 4'd4;
  localparam logic [3:0] RESET_PERIODS = 4'd4;

  // timing of the host-made link clock
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         LINK_PERIOD_NS = 80;
  localparam logic [3:0] HALF_CYCLES    = 4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // host adapter register offsets and status bits
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_WDATA  = 4'h1;
  localparam logic [3:0] HREG_STATUS = 4'h2;
  localparam logic [3:0] HREG_RDATA  = 4'h3;
  localparam logic [3:0] HREG_RESET  = 4'h4;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_DONE   = 1;

  // true for the four valid flash command codes
  function automatic logic is_flash_cmd(input logic [7:0] b);
    return b == CMD_BLOCK_READ || b == CMD_BLOCK_WRITE || b == CMD_PAGE_ERASE || b == CMD_DEVICE_ERASE;
  endfunction
endpackage

// ===== logic/dbg_link_if.sv
// three-wire debug link (clock, reset, data) between host adapter and target
`timescale 1ns/1ps
interface dbg_link_if;
  logic link_clk;
  logic link_reset_n;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data;

  // pulled high when nobody drives the data wire
  assign data = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);

  modport host (output link_clk, output link_reset_n, output host_data_o, output host_data_oe, input data);
  modport device (input link_clk, input link_reset_n, input data, output dev_data_o, output dev_data_oe);
endinterface

// ===== logic/dbg_target.sv
// target end: debug link registers, programming unlock and core-side crossing
// How it works
// - read-only part code at 0xFD, SFR page 0x0F
// - read-only revision code at 0xFE
// - program enable after codes 0x02 then 0x01
// - program mode holds until system reset
// - data register carries commands, addresses, data
// - decode block read/write, page/device erase
// - halted state stalls peripherals and program
// - halted target lends both pins to link
// - host selects register before data access
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module dbg_target
  import dbg_link_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = REV_ID_DEFAULT
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  dbg_link_if.device    link,
  input  wire logic     halt_req,
  output logic          core_stalled,
  output logic          pins_borrowed,
  output logic          prog_mode,
  output logic [7:0]    flash_byte,
  output logic          flash_byte_valid,
  output flash_cmd_type flash_cmd,
  output logic          flash_cmd_valid,
  input  wire logic [7:0] flash_ret_byte,
  input  wire logic     flash_ret_valid,
  input  wire logic [7:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  output logic [7:0]    sfr_rdata
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_HDR  = 3'b001,
    D_WDAT = 3'b010,
    D_TURN = 3'b011,
    D_RDAT = 3'b100
  } dev_fsm_type;

  // everything clocked by the link clock
  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        ret_s1;
    logic        ret_s2;
    logic        ret_s3;
    dev_fsm_type fsm;
    logic [3:0]  bit_cnt;
    logic [1:0]  ins;
    logic [7:0]  shift;
    logic [7:0]  sel;
    logic [7:0]  ctrl;
    logic [7:0]  pdata;
    logic        unlock_armed;
    logic        prog_en;
    logic        cmd_expected;
    logic        evt_tgl;
    logic [7:0]  evt_byte;
    logic        evt_is_cmd;
    logic        out_bit;
    logic        out_en;
  } lnk_state_type;

  // everything clocked by the core clock
  typedef struct packed {
    logic          sys_s1;
    logic          sys_s2;
    logic          en_s1;
    logic          en_s2;
    logic          evt_s1;
    logic          evt_s2;
    logic          evt_s3;
    logic          prog_mode;
    logic          stalled;
    logic          borrowed;
    logic [7:0]    byte_q;
    logic          byte_valid;
    flash_cmd_type cmd;
    logic          cmd_valid;
    logic          ret_tgl;
    logic [7:0]    ret_byte;
    logic [7:0]    sfr_rdata;
  } core_state_type;

  lnk_state_type  lq;
  lnk_state_type  ld;
  core_state_type cq;
  core_state_type cd;

  // value returned for a data read of the selected register
  function automatic logic [7:0] read_value(input logic [7:0] sel, input logic [7:0] ctrl,
                                            input logic [7:0] pdata);
    unique case (sel)
      SEL_PART, SEL_PART_ALT: return PART_ID_VALUE;
      SEL_REV, SEL_REV_ALT:   return SILICON_REV;
      SEL_PROG_CONTROL:       return ctrl;
      SEL_PROG_DATA:          return pdata;
      default:                return 8'h00;
    endcase
  endfunction

  // link side: frame decoder and register file
  always_comb begin
    logic [1:0] ins_now;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    ins_now = {link.data, lq.ins[1]};
    wbyte   = {link.data, lq.shift[7:1]};
    rbyte   = 8'h00;
    ld        = lq;
    ld.rst_s1 = link.link_reset_n;
    ld.rst_s2 = lq.rst_s1;
    ld.ret_s1 = cq.ret_tgl;
    ld.ret_s2 = lq.ret_s1;
    ld.ret_s3 = lq.ret_s2;
    if (!lq.rst_s2) begin
      ld.fsm          = D_IDLE;
      ld.bit_cnt      = 4'd0;
      ld.ins          = 2'b00;
      ld.shift        = 8'h00;
      ld.sel          = REG_RESET;
      ld.ctrl         = REG_RESET;
      ld.pdata        = REG_RESET;
      ld.unlock_armed = 1'b0;
      ld.prog_en      = 1'b0;                         // only a reset clears it
      ld.cmd_expected = 1'b0;
      ld.evt_tgl      = 1'b0;
      ld.evt_byte     = 8'h00;
      ld.evt_is_cmd   = 1'b0;
      ld.out_bit      = 1'b0;
      ld.out_en       = 1'b0;
    end else begin
      // returned flash byte lands in the data register; a host write in the same frame edge wins
      if (lq.ret_s2 != lq.ret_s3) begin
        ld.pdata = cq.ret_byte;
      end
      unique case (lq.fsm)
        D_IDLE: begin
          if (!link.data) begin
            ld.fsm     = D_HDR;
            ld.bit_cnt = 4'd1;
          end
        end
        D_HDR: begin
          ld.ins     = ins_now;
          ld.bit_cnt = lq.bit_cnt + 4'd1;
          if (lq.bit_cnt == 4'd2) begin
            ld.bit_cnt = 4'd0;
            ld.fsm     = ins_now[0] ? D_WDAT : D_TURN;
          end
        end
        D_WDAT: begin
          ld.shift   = wbyte;
          ld.bit_cnt = lq.bit_cnt + 4'd1;
          if (lq.bit_cnt == 4'd7) begin
            ld.fsm = D_IDLE;
            if (lq.ins == INS_ADDR_WRITE) begin
              ld.sel          = wbyte;
              ld.cmd_expected = 1'b1;
            end else begin
              unique case (lq.sel)
                SEL_PROG_CONTROL: begin
                  ld.ctrl = wbyte;
                  // ordered unlock: any other byte in between disarms it
                  if (!lq.prog_en) begin
                    ld.prog_en      = lq.unlock_armed && (wbyte == UNLOCK_SECOND);
                    ld.unlock_armed = (wbyte == UNLOCK_FIRST);
                  end
                end
                SEL_PROG_DATA: begin
                  ld.pdata = wbyte;
                  if (lq.prog_en) begin
                    ld.evt_byte     = wbyte;
                    ld.evt_is_cmd   = lq.cmd_expected && is_flash_cmd(wbyte);
                    ld.evt_tgl      = ~lq.evt_tgl;
                    ld.cmd_expected = 1'b0;
                  end
                end
                default: ;                            // identification and unmapped writes dropped
              endcase
            end
          end
        end
        D_TURN: begin
          // data goes out one period after the header so host and target never fight
          rbyte      = (lq.ins == INS_ADDR_READ) ? lq.sel : read_value(lq.sel, lq.ctrl, lq.pdata);
          ld.out_bit = rbyte[0];
          ld.out_en  = 1'b1;
          ld.shift   = {1'b0, rbyte[7:1]};
          ld.bit_cnt = 4'd1;
          ld.fsm     = D_RDAT;
        end
        D_RDAT: begin
          if (lq.bit_cnt == 4'd8) begin
            ld.out_en = 1'b0;
            ld.fsm    = D_IDLE;
          end else begin
            ld.out_bit = lq.shift[0];
            ld.shift   = {1'b0, lq.shift[7:1]};
            ld.bit_cnt = lq.bit_cnt + 4'd1;
          end
        end
        default: ld.fsm = D_IDLE;
      endcase
    end
  end

  // the link clock may stop between frames; state simply waits for the next edge
  always_ff @(posedge link.link_clk) begin
    lq <= ld;
  end

  assign link.dev_data_o  = lq.out_bit;
  assign link.dev_data_oe = lq.out_en;

  // core side: system reset, program mode, stall and flash byte hand-off
  always_comb begin
    cd            = cq;
    cd.sys_s1     = link.link_reset_n;
    cd.sys_s2     = cq.sys_s1;
    cd.en_s1      = lq.prog_en;
    cd.en_s2      = cq.en_s1;
    cd.evt_s1     = lq.evt_tgl;
    cd.evt_s2     = cq.evt_s1;
    cd.evt_s3     = cq.evt_s2;
    cd.byte_valid = 1'b0;
    cd.cmd_valid  = 1'b0;
    if (!rst_n || !cq.sys_s2) begin
      cd.prog_mode = 1'b0;
      cd.stalled   = 1'b0;
      cd.borrowed  = 1'b0;
      cd.byte_q    = 8'h00;
      cd.cmd       = CMD_BLOCK_READ;
      cd.ret_tgl   = 1'b0;
      cd.ret_byte  = 8'h00;
      cd.sfr_rdata = 8'h00;
    end else begin
      // sticky until system reset, so the core cannot drift back to normal running
      cd.prog_mode = cq.prog_mode | cq.en_s2;
      cd.stalled   = halt_req | cd.prog_mode;
      cd.borrowed  = cd.stalled;
      // byte register stood still for at least two core cycles before the toggle arrives
      if (cq.evt_s2 != cq.evt_s3) begin
        cd.byte_q     = lq.evt_byte;
        cd.byte_valid = 1'b1;
        if (lq.evt_is_cmd) begin
          cd.cmd       = flash_cmd_type'(lq.evt_byte);
          cd.cmd_valid = 1'b1;
        end
      end
      if (flash_ret_valid) begin
        cd.ret_byte = flash_ret_byte;
        cd.ret_tgl  = ~cq.ret_tgl;
      end
      cd.sfr_rdata = 8'h00;
      if (sfr_page == SFR_PAGE_ID && sfr_addr == SEL_PART) begin
        cd.sfr_rdata = PART_ID_VALUE;
      end else if (sfr_page == SFR_PAGE_ID && sfr_addr == SEL_REV) begin
        cd.sfr_rdata = SILICON_REV;
      end
    end
  end

  always_ff @(posedge clk) begin
    cq <= cd;
  end

  assign core_stalled     = cq.stalled;
  assign pins_borrowed    = cq.borrowed;
  assign prog_mode        = cq.prog_mode;
  assign flash_byte       = cq.byte_q;
  assign flash_byte_valid = cq.byte_valid;
  assign flash_cmd        = cq.cmd;
  assign flash_cmd_valid  = cq.cmd_valid;
  assign sfr_rdata        = cq.sfr_rdata;

endmodule // dbg_target

// ===== logic/dbg_host_adapter.sv
// host end: register port, link clock divider and frame sequencer
`timescale 1ns/1ps
module dbg_host_adapter
  import dbg_link_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  dbg_link_if.host        link,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic [7:0]      reg_rdata
);

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_RESET = 2'b01,
    H_FRAME = 2'b10
  } host_fsm_type;

  typedef struct packed {
    host_fsm_type fsm;
    logic [3:0]   div;
    logic         clk_hi;
    logic [3:0]   bit_idx;
    link_ins_type ins;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic [7:0]   shift;
    logic         done;
    logic         lreset_n;
    logic         dout;
    logic         doe;
    logic         din_s1;
    logic         din_s2;
    logic [7:0]   rd;
  } host_state_type;

  host_state_type q;
  host_state_type d;

  always_comb begin
    logic [3:0] nb;
    logic [3:0] k;
    logic       wr;
    nb        = q.bit_idx + 4'd1;
    k         = nb - DATA_FIRST;
    wr        = q.ins[0];
    d         = q;
    d.din_s1  = link.data;
    d.din_s2  = q.din_s1;
    d.rd      = 8'h00;
    if (!rst_n) begin
      // coming out of reset the host first resets the target through the link
      d.fsm      = H_RESET;
      d.div      = 4'd0;
      d.clk_hi   = 1'b0;
      d.bit_idx  = 4'd0;
      d.ins      = INS_DATA_READ;
      d.wdata    = 8'h00;
      d.rdata    = 8'h00;
      d.shift    = 8'h00;
      d.done     = 1'b0;
      d.lreset_n = 1'b0;
      d.dout     = 1'b1;
      d.doe      = 1'b0;
    end else begin
      // register port: read data stands only in the cycle after the strobe
      if (reg_re) begin
        unique case (reg_addr)
          HREG_WDATA:  d.rd = q.wdata;
          HREG_STATUS: d.rd = {6'h00, q.done, q.fsm != H_IDLE};
          HREG_RDATA:  d.rd = q.rdata;
          default:     d.rd = 8'h00;
        endcase
      end
      if (reg_we) begin
        unique case (reg_addr)
          HREG_WDATA: d.wdata = reg_wdata;
          HREG_STATUS: begin
            if (reg_wdata[STAT_DONE]) begin
              d.done = 1'b0;
            end
          end
          HREG_CMD: begin
            // commands while busy are dropped; software polls busy first
            if (q.fsm == H_IDLE) begin
              d.fsm     = H_FRAME;
              d.ins     = link_ins_type'(reg_wdata[1:0]);
              d.div     = 4'd0;
              d.clk_hi  = 1'b0;
              d.bit_idx = 4'd0;
              d.dout    = 1'b0;
              d.doe     = 1'b1;
            end
          end
          HREG_RESET: begin
            if (q.fsm == H_IDLE) begin
              d.fsm      = H_RESET;
              d.div      = 4'd0;
              d.clk_hi   = 1'b0;
              d.bit_idx  = 4'd0;
              d.lreset_n = 1'b0;
            end
          end
          default: ;
        endcase
      end
      // divider: the link clock only runs while a frame or reset is going
      if (q.fsm != H_IDLE) begin
        d.div = q.div + 4'd1;
        if (q.div == HALF_CYCLES - 4'd1) begin
          d.div    = 4'd0;
          d.clk_hi = ~q.clk_hi;
          if (q.clk_hi) begin
            // falling edge: new bit period starts, outputs change away from the target's rising edge
            d.bit_idx = nb;
            if (q.fsm == H_RESET) begin
              if (nb == RESET_PERIODS) begin
                d.lreset_n = 1'b1;
              end
              if (nb == RESET_PERIODS + RESET_PERIODS) begin
                d.fsm  = H_IDLE;
                d.done = 1'b1;
              end
            end else if (nb == FRAME_BITS) begin
              d.fsm  = H_IDLE;
              d.doe  = 1'b0;
              d.done = 1'b1;
              if (!wr) begin
                d.rdata = q.shift;
              end
            end else begin
              if (!wr && nb >= SAMPLE_FIRST) begin
                d.shift = {q.din_s2, q.shift[7:1]};
              end
              unique case (nb)
                4'd1: d.dout = q.ins[0];
                4'd2: d.dout = q.ins[1];
                default: begin
                  d.doe  = wr;
                  d.dout = (nb < FRAME_BITS - 4'd1) ? q.wdata[k[2:0]] : 1'b1;
                end
              endcase
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign link.link_clk     = q.clk_hi;
  assign link.link_reset_n = q.lreset_n;
  assign link.host_data_o  = q.dout;
  assign link.host_data_oe = q.doe;
  assign reg_rdata         = q.rd;

endmodule // dbg_host_adapter

// ===== sim/dbg_link_asserts.sv
// wire-level checks on the debug link between host adapter and target
`timescale 1ns/1ps
module dbg_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic data
);
  logic [7:0] oe_run_q;
  logic [7:0] oe_run_d;
  logic [7:0] rst_run_q;
  logic [7:0] rst_run_d;

  // run lengths in core clocks; frame and reset lengths are judged on them
  always_comb begin
    oe_run_d  = host_data_oe ? oe_run_q + 8'h01 : 8'h00;
    rst_run_d = link_reset_n ? 8'h00 : rst_run_q + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_run_q  <= 8'h00;
      rst_run_q <= 8'h00;
    end else begin
      oe_run_q  <= oe_run_d;
      rst_run_q <= rst_run_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_high_phase;
    link_clk [*4] ##1 !link_clk;
  endsequence

  property p_link_high;   $rose(link_clk) |-> s_high_phase; endproperty
  property p_no_contend;  !(host_data_oe && dev_data_oe); endproperty
  property p_start;       $rose(host_data_oe) |-> !host_data_o; endproperty
  property p_host_edge;   host_data_oe && $past(host_data_oe) && $changed(host_data_o) |-> !link_clk; endproperty
  property p_stop;        $fell(host_data_oe) && oe_run_q > 8'd60 |-> $past(host_data_o); endproperty
  property p_frame_len;   $fell(host_data_oe) |-> oe_run_q inside {[8'd22:8'd26], [8'd94:8'd98]}; endproperty
  // the target's link side resets only on link edges, so it gets three link rises before it must be quiet
  property p_dev_quiet;   !link_reset_n && rst_run_q > 8'h15 |-> !dev_data_oe; endproperty
  property p_rst_len;     $rose(link_reset_n) |-> rst_run_q inside {[8'd30:8'd40]}; endproperty
  property p_dev_turn;    $rose(dev_data_oe) |-> !host_data_oe ##0 !$past(host_data_oe); endproperty

  a_link_high: assert property (p_link_high) else $error("link clock high phase wrong length");
  a_no_contend: assert property (p_no_contend) else $error("both ends drive the data wire");
  a_start: assert property (p_start) else $error("frame does not open with a low start bit");
  a_host_edge: assert property (p_host_edge) else $error("host data moved while link clock high");
  a_stop: assert property (p_stop) else $error("write frame does not end with a high bit");
  a_frame_len: assert property (p_frame_len) else $error("host drive length is not a frame length");
  a_dev_quiet: assert property (p_dev_quiet) else $error("target drives during link reset");
  a_rst_len: assert property (p_rst_len) else $error("link reset low phase wrong length");
  a_dev_turn: assert property (p_dev_turn) else $error("target drives before host release");
endmodule // dbg_link_asserts

// ===== sim/debug_flash_prog_regs_tb.sv
// testbench: host adapter and target joined by the debug link
`timescale 1ns/1ps
module debug_flash_prog_regs_tb
  import dbg_link_pkg::*;
;
  localparam logic [7:0] REV = 8'h3C;
  localparam logic [7:0] CODES [5] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h05};
  localparam logic [7:0] ID_SEL [4] = '{SEL_PART_ALT, SEL_PART, SEL_REV_ALT, SEL_REV};
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_we = 1'b0;
  logic          reg_re = 1'b0;
  logic [7:0]    reg_rdata;
  logic          halt_req = 1'b0;
  logic [7:0]    flash_ret_byte = 8'h00;
  logic          flash_ret_valid = 1'b0;
  logic [7:0]    sfr_page = 8'h00;
  logic [7:0]    sfr_addr = 8'h00;
  logic [7:0]    sfr_rdata;
  logic          core_stalled, pins_borrowed, prog_mode, flash_byte_valid, flash_cmd_valid;
  logic [7:0]    flash_byte;
  flash_cmd_type flash_cmd;
  logic [7:0]    last_cmd, last_byte;
  logic [15:0]   seed = 16'h3F83;
  int            n_cmd = 0;
  int            n_byte = 0;
  int            fails = 0;
  int            n_compared = 0;

  dbg_link_if u_dbg_link_if ();
  dbg_host_adapter u_dbg_host_adapter (.clk(clk), .rst_n(rst_n), .link(u_dbg_link_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  dbg_target #(.SILICON_REV(REV)) u_dbg_target (.clk(clk), .rst_n(rst_n), .link(u_dbg_link_if),
    .halt_req(halt_req), .core_stalled(core_stalled), .pins_borrowed(pins_borrowed), .prog_mode(prog_mode),
    .flash_byte(flash_byte), .flash_byte_valid(flash_byte_valid), .flash_cmd(flash_cmd),
    .flash_cmd_valid(flash_cmd_valid), .flash_ret_byte(flash_ret_byte), .flash_ret_valid(flash_ret_valid),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata));
  dbg_link_asserts u_dbg_link_asserts (.clk(clk), .rst_n(rst_n), .link_clk(u_dbg_link_if.link_clk),
    .link_reset_n(u_dbg_link_if.link_reset_n), .host_data_o(u_dbg_link_if.host_data_o),
    .host_data_oe(u_dbg_link_if.host_data_oe), .dev_data_o(u_dbg_link_if.dev_data_o),
    .dev_data_oe(u_dbg_link_if.dev_data_oe), .data(u_dbg_link_if.data));

  always #5 clk = ~clk;

  // record core-side flash pulses; they last one cycle only
  always @(posedge clk) begin
    if (flash_cmd_valid) begin
      n_cmd    <= n_cmd + 1;
      last_cmd <= flash_cmd;
    end
    if (flash_byte_valid) begin
      n_byte    <= n_byte + 1;
      last_byte <= flash_byte;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // poll status; a bound that runs out ends the run
  task automatic wait_idle(input logic need_done);
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      reg_rd(HREG_STATUS, s);
      if (s[STAT_BUSY] === 1'b0 && (s[STAT_DONE] === 1'b1 || !need_done)) return;
    end
    fails++;
    print_verdict();
  endtask

  task automatic link_op(input link_ins_type ins, input logic [7:0] wd, output logic [7:0] rd);
    reg_wr(HREG_WDATA, wd);
    reg_wr(HREG_CMD, {6'h00, ins});
    wait_idle(1'b0);
    reg_rd(HREG_RDATA, rd);
  endtask

  task automatic tgt_wr(input logic [7:0] sel, input logic [7:0] d);
    logic [7:0] r;
    link_op(INS_ADDR_WRITE, sel, r);
    link_op(INS_DATA_WRITE, d, r);
  endtask

  task automatic tgt_rd(input logic [7:0] sel, output logic [7:0] d);
    logic [7:0] r;
    link_op(INS_ADDR_WRITE, sel, r);
    link_op(INS_DATA_READ, 8'h00, d);
  endtask

  task automatic sfr_chk(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_page <= p;
    sfr_addr <= a;
    @(posedge clk);
    #1;
    cmp_byte(sfr_rdata, e);
  endtask

  initial begin
    logic [7:0] r;
    int         c0;
    int         b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle(1'b1);
    tgt_rd(SEL_PROG_CONTROL, r);
    cmp_byte(r, REG_RESET);
    tgt_rd(SEL_PROG_DATA, r);
    cmp_byte(r, REG_RESET);
    link_op(INS_ADDR_READ, 8'h00, r);
    cmp_byte(r, SEL_PROG_DATA);
    tgt_rd(8'h55, r);
    cmp_byte(r, 8'h00);
    reg_rd(4'h7, r);
    cmp_byte(r, 8'h00);
    // staged write byte reads back unchanged
    seed = lfsr(seed);
    reg_wr(HREG_WDATA, seed[7:0]);
    reg_rd(HREG_WDATA, r);
    cmp_byte(r, seed[7:0]);
    // identification registers ignore writes under both selections
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      tgt_wr(ID_SEL[i], seed[7:0]);
      tgt_rd(ID_SEL[i], r);
      cmp_byte(r, (i < 2) ? PART_ID_VALUE : REV);
    end
    sfr_chk(SFR_PAGE_ID, SEL_PART, PART_ID_VALUE);
    sfr_chk(SFR_PAGE_ID, SEL_REV, REV);
    sfr_chk(8'h00, SEL_PART, 8'h00);
    // random halt levels while programming is still locked
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      halt_req <= seed[0];
      @(posedge clk);
      #1;
      cmp_bit(core_stalled, seed[0]);
      cmp_bit(pins_borrowed, seed[0]);
    end
    @(posedge clk);
    halt_req <= 1'b0;
    // wrong order and a stray code between must not unlock
    link_op(INS_ADDR_WRITE, SEL_PROG_CONTROL, r);
    link_op(INS_DATA_WRITE, UNLOCK_SECOND, r);
    link_op(INS_DATA_WRITE, UNLOCK_FIRST, r);
    link_op(INS_DATA_WRITE, 8'h05, r);
    link_op(INS_DATA_WRITE, UNLOCK_SECOND, r);
    repeat (10) @(posedge clk);
    #1;
    cmp_bit(prog_mode, 1'b0);
    link_op(INS_DATA_WRITE, UNLOCK_FIRST, r);
    link_op(INS_DATA_WRITE, UNLOCK_SECOND, r);
    repeat (10) @(posedge clk);
    #1;
    cmp_bit(prog_mode, 1'b1);
    // every command code, one invalid, each followed by an operand byte
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      c0 = n_cmd;
      b0 = n_byte;
      tgt_wr(SEL_PROG_DATA, CODES[i]);
      link_op(INS_DATA_WRITE, seed[7:0], r);
      cmp_byte(8'(n_cmd - c0), (i < 4) ? 8'h01 : 8'h00);
      if (i < 4) cmp_byte(last_cmd, CODES[i]);
      cmp_byte(8'(n_byte - b0), 8'h02);
      cmp_byte(last_byte, seed[7:0]);
    end
    seed = lfsr(seed);
    @(posedge clk);
    flash_ret_byte  <= seed[7:0];
    flash_ret_valid <= 1'b1;
    @(posedge clk);
    flash_ret_valid <= 1'b0;
    tgt_rd(SEL_PROG_DATA, r);
    cmp_byte(r, seed[7:0]);
    cmp_bit(core_stalled, 1'b1);
    cmp_bit(pins_borrowed, 1'b1);
    cmp_bit(prog_mode, 1'b1);
    // only a system reset over the link leaves programming mode
    reg_wr(HREG_STATUS, 8'h02);
    reg_wr(HREG_RESET, 8'h00);
    wait_idle(1'b1);
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(prog_mode, 1'b0);
    tgt_rd(SEL_PROG_CONTROL, r);
    cmp_byte(r, REG_RESET);
    print_verdict();
  end
endmodule // debug_flash_prog_regs_tb
